/* File: src/asc_core.sv */
/*
 * Audio serial transfer control core: register file, master clock selection,
 * bit clock and word select generation, serial shifting and RAM word movement.
 * Assumes a classic Wishbone master, a RAM that answers a read in the same
 * cycle as its registered address, and pin inputs synchronous to sys_clk.
 */
`timescale 1ns/1ps

module asc_core (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [asc_pkg::ASC_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_timer_input_pin,
   input wire logic pll_clock_in,
   input wire logic serial_data_in_p00,
   input wire logic serial_data_in_p05,
   input wire logic [12:0] prog_count,
   input wire logic [12:0] prog_addr,
   input wire logic [23:0] ram_rdata,
   output logic [12:0] ram_addr,
   output logic ram_rd,
   output logic ram_wr,
   output logic [23:0] ram_wdata,
   output logic bit_clock,
   output logic word_select_clock,
   output logic serial_data_line,
   output logic [12:0] work_count,
   output logic [12:0] work_addr,
   output logic transfer_start_irq,
   output logic transfer_end_irq
);
   import asc_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic ack;
      logic [7:0] dat;
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] clk;
      logic [7:0] rate;
      logic [7:0] src;
      logic mclk_s1;
      logic mclk_s2;
      logic mclk_d;
      logic pll_s;
      logic pll_d;
      logic [2:0] div;
      logic bclk;
      logic ws;
      logic [5:0] pos;
      logic chan;
      logic [23:0] txw;
      logic [23:0] rxw;
      logic sdo;
      asc_xfer_type xf;
      logic [12:0] wcnt;
      logic [12:0] wadr;
      logic rd;
      logic wr;
      logic [23:0] wdata;
      logic [12:0] addr;
      logic irq_s;
      logic irq_e;
   } asc_state_type;

   asc_state_type state_r;
   asc_state_type state_nxt;

   // ==========================================================
   // Helpers
   function automatic logic [7:0] reg_read(input logic [15:0] idx, input asc_state_type s);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         ASC_IDX_CTRL: v = s.ctrl;
         ASC_IDX_MODE: v = s.mode;
         ASC_IDX_CLK: v = s.clk;
         ASC_IDX_RATE: v = s.rate;
         ASC_IDX_SRC: v = s.src;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Bit of the word for frame slot p, or 0 outside the data window
   function automatic logic slot_bit(input logic [23:0] w, input logic [5:0] p,
                                     input logic [5:0] first, input logic [5:0] len,
                                     input logic msb);
      logic [5:0] k;
      logic [5:0] idx;
      logic b;
      k = p - first;
      idx = msb ? (len - 6'h01 - k) : k;
      b = 1'b0;
      if (p >= first && k < len) begin
         b = w[idx[4:0]];
      end
      return b;
   endfunction

   // ==========================================================
   // Decoded settings
   logic [15:0] idx;
   logic hit;
   logic [5:0] len;
   logic [5:0] half;
   logic [5:0] first;
   logic [2:0] tog;
   logic [12:0] bpw;
   logic mtick;
   logic ser_in;
   logic msb;
   logic pol;

   always_comb begin
      idx = wb_adr_i[17:2];
      hit = wb_cyc_i & wb_stb_i & ~state_r.ack;
      msb = state_r.ctrl[ASC_CTRL_MSB];
      pol = state_r.clk[ASC_CLK_WSPOL];
      case (state_r.mode[ASC_MODE_LEN_HI:ASC_MODE_LEN_LO])
         2'b00: len = ASC_LEN_16; // RULE_14
         2'b01: len = ASC_LEN_18;
         2'b10: len = ASC_LEN_20;
         default: len = ASC_LEN_24;
      endcase
      bpw = (len == ASC_LEN_16) ? ASC_BPW_2 : ASC_BPW_3;
      half = state_r.clk[ASC_CLK_RATE] ? ASC_HALF_64 : ASC_HALF_48; // RULE_02
      if (state_r.mode[ASC_MODE_JUST]) begin
         first = half - len; // RULE_15
      end else if (state_r.mode[ASC_MODE_I2S]) begin
         first = 6'h01; // RULE_17
      end else begin
         first = 6'h00;
      end
      case (state_r.rate[1:0])
         2'b00: tog = state_r.clk[ASC_CLK_RATE] ? ASC_TOG_6 : ASC_TOG_8; // RULE_01
         2'b01: tog = ASC_TOG_4;
         default: tog = ASC_TOG_2;
      endcase
      if (state_r.mode[ASC_MODE_EXTMC]) begin
         mtick = state_r.mclk_s2 & ~state_r.mclk_d; // RULE_19
      end else if (state_r.src[ASC_SRC_SYS]) begin
         mtick = 1'b1;
      end else begin
         mtick = state_r.pll_s & ~state_r.pll_d;
      end
      ser_in = state_r.mode[ASC_MODE_INSEL] ? serial_data_in_p00 : serial_data_in_p05; // RULE_16
   end

   // ==========================================================
   // Next state
   always_comb begin
      logic set_sta;
      logic set_end;
      logic boundary;
      logic [5:0] np;
      set_sta = 1'b0;
      set_end = 1'b0;
      boundary = 1'b0;
      np = state_r.pos;
      state_nxt = state_r;
      state_nxt.ack = 1'b0;
      state_nxt.rd = 1'b0;
      state_nxt.wr = 1'b0;

      // Register slave: one wait state, unmapped reads give zero
      if (hit) begin
         state_nxt.ack = 1'b1;
         state_nxt.dat = reg_read(idx, state_r);
         if (wb_we_i && wb_sel_i[0]) begin
            case (idx)
               ASC_IDX_CTRL: state_nxt.ctrl = wb_dat_i[7:0];
               ASC_IDX_MODE: state_nxt.mode = wb_dat_i[7:0];
               ASC_IDX_CLK: state_nxt.clk = wb_dat_i[7:0];
               ASC_IDX_RATE: state_nxt.rate = wb_dat_i[7:0];
               ASC_IDX_SRC: state_nxt.src = wb_dat_i[7:0];
               default: state_nxt.dat = 8'h00;
            endcase
         end
      end

      // Two flops before the edge detector on the foreign clock
      state_nxt.mclk_s1 = external_timer_input_pin; // RULE_25
      state_nxt.mclk_s2 = state_r.mclk_s1;
      state_nxt.mclk_d = state_r.mclk_s2;
      state_nxt.pll_s = pll_clock_in;
      state_nxt.pll_d = state_r.pll_s;

      if (!state_nxt.ctrl[ASC_CTRL_START]) begin
         // Clocks, shifting and transfer state held initial; work count, address and flags kept
         state_nxt.div = 3'h0; // RULE_04
         state_nxt.bclk = 1'b0;
         state_nxt.pos = 6'h00;
         state_nxt.chan = 1'b0;
         state_nxt.ws = ~pol;
         state_nxt.sdo = 1'b0;
         state_nxt.txw = 24'h000000;
         state_nxt.rxw = 24'h000000;
         state_nxt.xf = ASC_XF_IDLE;
         state_nxt.ctrl[ASC_CTRL_RUN] = 1'b0;
      end else begin
         if (state_r.rd) begin
            // Word fetched at the boundary replaces the slot-0 bit
            state_nxt.txw = ram_rdata;
            state_nxt.sdo = slot_bit(ram_rdata, state_r.pos, first, len, msb);
         end
         if (mtick) begin // RULE_03
            if (state_r.div == tog - 3'h1) begin
               state_nxt.div = 3'h0;
               state_nxt.bclk = ~state_r.bclk;
               if (state_r.bclk) begin
                  // Falling edge: advance slot, drive new bit
                  if (state_r.pos == half - 6'h01) begin
                     np = 6'h00;
                     boundary = 1'b1;
                     state_nxt.chan = ~state_r.chan;
                  end else begin
                     np = state_r.pos + 6'h01;
                  end
                  state_nxt.pos = np;
                  state_nxt.ws = state_nxt.chan ^ ~pol; // RULE_18
                  state_nxt.sdo = slot_bit(state_r.txw, np, first, len, msb); // RULE_11
               end else if (slot_bit(24'hffffff, state_r.pos, first, len, 1'b0)) begin
                  // Rising edge: capture receive bit in its slot
                  if (msb) begin
                     state_nxt.rxw[5'(len - 6'h01 - (state_r.pos - first))] = ser_in;
                  end else begin
                     state_nxt.rxw[5'(state_r.pos - first)] = ser_in;
                  end
               end
            end else begin
               state_nxt.div = state_r.div + 3'h1;
            end
         end

         // Word movement at each channel boundary
         if (!state_nxt.ctrl[ASC_CTRL_RUN]) begin
            state_nxt.xf = ASC_XF_IDLE; // RULE_07
         end else if (boundary) begin // RULE_05
            case (state_r.xf)
               ASC_XF_IDLE: begin
                  set_sta = 1'b1; // RULE_20
                  state_nxt.wcnt = prog_count; // RULE_21
                  state_nxt.wadr = prog_addr;
                  state_nxt.xf = ASC_XF_BUSY;
               end
               ASC_XF_BUSY: state_nxt.xf = ASC_XF_BUSY;
               default: state_nxt.xf = ASC_XF_IDLE;
            endcase
            state_nxt.addr = set_sta ? prog_addr : state_r.wadr;
            state_nxt.rd = 1'b1;
            state_nxt.wr = state_r.ctrl[ASC_CTRL_DIR]; // RULE_10
            state_nxt.wdata = state_r.rxw;
            state_nxt.wadr = state_nxt.addr + bpw;
            if ((set_sta ? prog_count : state_r.wcnt) <= bpw) begin
               set_end = 1'b1; // RULE_12
               state_nxt.wcnt = 13'h0000;
               state_nxt.xf = ASC_XF_IDLE;
               if (state_r.ctrl[ASC_CTRL_AUTO]) begin
                  state_nxt.ctrl[ASC_CTRL_RUN] = 1'b0; // RULE_08
               end
            end else begin
               state_nxt.wcnt = (set_sta ? prog_count : state_r.wcnt) - bpw;
            end
         end
      end

      // Hardware set wins over a software clear in the same cycle
      if (set_sta) begin
         state_nxt.mode[ASC_MODE_STAF] = 1'b1;
      end
      if (set_end) begin
         state_nxt.ctrl[ASC_CTRL_ENDF] = 1'b1;
      end
      state_nxt.irq_s = state_nxt.mode[ASC_MODE_STAF] & state_nxt.mode[ASC_MODE_STAIE]; // RULE_22
      state_nxt.irq_e = state_nxt.ctrl[ASC_CTRL_ENDF] & state_nxt.ctrl[ASC_CTRL_ENDIE]; // RULE_13
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= '0;
         state_r.ctrl <= ASC_RST_REG;
         state_r.mode <= ASC_RST_REG;
         state_r.clk <= ASC_RST_REG;
         state_r.rate <= ASC_RST_REG;
         state_r.src <= ASC_RST_REG;
         state_r.ws <= 1'b1;
         state_r.xf <= ASC_XF_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o = state_r.ack;
   assign wb_dat_o = {24'h000000, state_r.dat};
   assign ram_addr = state_r.addr;
   assign ram_rd = state_r.rd;
   assign ram_wr = state_r.wr;
   assign ram_wdata = state_r.wdata;
   assign bit_clock = state_r.bclk;
   assign word_select_clock = state_r.ws;
   assign serial_data_line = state_r.sdo;
   assign work_count = state_r.wcnt;
   assign work_addr = state_r.wadr;
   assign transfer_start_irq = state_r.irq_s;
   assign transfer_end_irq = state_r.irq_e;

endmodule

/* File: src/asc_pkg.sv */
/*
 * Constants, register map and state types of the audio serial transfer control core.
 * Assumes a classic Wishbone master with 32-bit data; registers use the low byte.
 */
//
// Overview of operation
// (RULE_01) Bit clock divides master clock per rate code
// (RULE_02) Bit-rate select: 1 gives 64 fs, 0 48 fs
// (RULE_03) Start bit 1 runs circuit and clocks
// (RULE_04) Start bit 0 initialises and stops everything; code keeps work count, address and flags
// (RULE_05) Run bit 1 starts RAM/buffer data movement
// (RULE_06) External clocks: wait two frames before run
// (RULE_07) Clearing run bit stops movement at once
// (RULE_08) Auto-stop clears run bit after count
// (RULE_09) Synchronous serial mode needs auto-stop set
// (RULE_10) Direction 1 receives too, 0 transmits only
// (RULE_11) Bit order: 1 MSB first, 0 LSB
// (RULE_12) End flag sets after count, sticky
// (RULE_13) End flag with enable raises end request
// (RULE_14) Length code: 16, 18, 20, 24 bits
// (RULE_15) Justification: 1 right, 0 left
// (RULE_16) Input pin: 1 first pin, 0 second
// (RULE_17) I2S framing delays data by one bit
// (RULE_18) Polarity 1: word select low is left
// (RULE_19) Master clock from timer pin or internal
// (RULE_20) Start flag sets on first word moved
// (RULE_21) Start flag copies count and address inside
// (RULE_22) Start flag with enable raises start request
// (RULE_23) PLL use needs oscillator, comparator enables set
// (RULE_24) Software writes zero to the test bit
// (RULE_25) Safe crossing of clock and status events; code has two flops on the timer pin, one on the PLL clock
package asc_pkg;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam int ASC_ADR_W = 18;
   localparam logic [15:0] ASC_IDX_CTRL = 16'hfeac;
   localparam logic [15:0] ASC_IDX_MODE = 16'hfec9;
   localparam logic [15:0] ASC_IDX_CLK = 16'hfeca;
   localparam logic [15:0] ASC_IDX_RATE = 16'hfeab;
   localparam logic [15:0] ASC_IDX_SRC = 16'hfed0;
   localparam logic [7:0] ASC_RST_REG = 8'h00;

   // ==========================================================
   // Field positions
   localparam int ASC_CTRL_START = 6;
   localparam int ASC_CTRL_RUN = 5;
   localparam int ASC_CTRL_AUTO = 4;
   localparam int ASC_CTRL_DIR = 3;
   localparam int ASC_CTRL_MSB = 2;
   localparam int ASC_CTRL_ENDF = 1;
   localparam int ASC_CTRL_ENDIE = 0;
   localparam int ASC_MODE_LEN_HI = 7;
   localparam int ASC_MODE_LEN_LO = 6;
   localparam int ASC_MODE_JUST = 5;
   localparam int ASC_MODE_INSEL = 4;
   localparam int ASC_MODE_I2S = 3;
   localparam int ASC_MODE_EXTMC = 2;
   localparam int ASC_MODE_STAF = 1;
   localparam int ASC_MODE_STAIE = 0;
   localparam int ASC_CLK_WSPOL = 2;
   localparam int ASC_CLK_RATE = 0;
   localparam int ASC_SRC_SYS = 0;

   // ==========================================================
   // Timing and framing counts
   localparam logic [2:0] ASC_TOG_8 = 3'h4;
   localparam logic [2:0] ASC_TOG_6 = 3'h3;
   localparam logic [2:0] ASC_TOG_4 = 3'h2;
   localparam logic [2:0] ASC_TOG_2 = 3'h1;
   localparam logic [5:0] ASC_HALF_48 = 6'h18;
   localparam logic [5:0] ASC_HALF_64 = 6'h20;
   localparam logic [5:0] ASC_LEN_16 = 6'h10;
   localparam logic [5:0] ASC_LEN_18 = 6'h12;
   localparam logic [5:0] ASC_LEN_20 = 6'h14;
   localparam logic [5:0] ASC_LEN_24 = 6'h18;
   localparam logic [12:0] ASC_BPW_2 = 13'h0002;
   localparam logic [12:0] ASC_BPW_3 = 13'h0003;

   typedef enum logic [0:0] {
      ASC_XF_IDLE,
      ASC_XF_BUSY
   } asc_xfer_type;

endpackage

/* File: verification/asc_checker.sv */
/* Port-level assertions for asc_core.
   Assumes a bind onto asc_core; control bits are shadowed from bus writes. */
`timescale 1ns/1ps

module asc_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ram_rd,
   input wire logic ram_wr,
   input wire logic bit_clock,
   input wire logic word_select_clock,
   input wire logic transfer_start_irq,
   input wire logic transfer_end_irq
);
   import asc_pkg::*;
   // ==========================================================
   // Shadow of written control bits, taken at the same edge as the core takes them
   logic [7:0] ctl_r;
   logic [7:0] mode_r;
   logic wr_ok;
   assign wr_ok = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl_r <= 8'h00;
         mode_r <= 8'h00;
      end else begin
         if (wr_ok && wb_adr_i[17:2] == ASC_IDX_CTRL) ctl_r <= wb_dat_i[7:0];
         if (wr_ok && wb_adr_i[17:2] == ASC_IDX_MODE) mode_r <= wb_dat_i[7:0];
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   // Reset itself is the antecedent, so no disable here
   a_reset_out: assert property (disable iff (1'b0) rst |=> word_select_clock && !bit_clock
      && !ram_rd && !ram_wr && !wb_ack_o && !transfer_end_irq && !transfer_start_irq)
      else $error("outputs not at reset level");
   a_stop_quiet: assert property (!ctl_r[6] && !$past(ctl_r[6]) |-> !bit_clock && !ram_rd)
      else $error("activity while stopped");
   a_tx_nowrite: assert property (!ctl_r[3] && !$past(ctl_r[3]) |-> !ram_wr)
      else $error("RAM write in transmit-only mode");
   a_wr_with_rd: assert property (ram_wr |-> ram_rd)
      else $error("RAM write without shared read cycle");
   a_move_spacing: assert property (ram_rd |=> !ram_rd [*8])
      else $error("RAM moves too close together");
   a_end_gate: assert property (!ctl_r[0] && !$past(ctl_r[0]) |-> !transfer_end_irq)
      else $error("end request while disabled");
   a_start_gate: assert property (!mode_r[0] && !$past(mode_r[0]) |-> !transfer_start_irq)
      else $error("start request while disabled");
endmodule

bind asc_core asc_checker i_asc_checker (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ram_rd, .ram_wr, .bit_clock,
   .word_select_clock, .transfer_start_irq, .transfer_end_irq);

/* File: verification/asc_codec.sv */
/* Far-side audio device model: echoes the serial line and captures each half frame.
   Assumes data changes on the falling and is taken on the rising bit clock. */
`timescale 1ns/1ps

module asc_codec (
   input wire logic bit_clock,
   input wire logic word_select_clock,
   input wire logic serial_data_line,
   output logic serial_data_in_p00,
   output logic serial_data_in_p05,
   output logic [31:0] frame
);
   logic [31:0] sh_r;
   logic ws_r;
   // Inverse on the second pin, so a wrong pin choice cannot pass
   assign serial_data_in_p00 = serial_data_line;
   assign serial_data_in_p05 = ~serial_data_line;
   always @(posedge bit_clock) begin
      ws_r <= word_select_clock;
      if (ws_r !== word_select_clock) begin
         frame <= sh_r;
         sh_r <= {31'h0, serial_data_line};
      end else begin
         sh_r <= {sh_r[30:0], serial_data_line};
      end
   end
endmodule

/* File: verification/tb_asc_core.sv */
/* Testbench for asc_core: a table of serial formats, then hand-written cases.
   Assumes asc_codec on the far side and a RAM that always returns one word. */
`timescale 1ns/1ps

module tb_asc_core;
   import asc_pkg::*;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] mode;
      logic [7:0] clk;
      logic [7:0] rate;
      logic [7:0] src;
      logic [31:0] per;
      logic [31:0] frame;
   } asc_row_type;
   logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [17:0] wb_adr_i = 18'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic external_timer_input_pin = 1'b0, pll_clock_in = 1'b0;
   logic [12:0] prog_count = 13'h1ffe, prog_addr = 13'h0;
   logic [23:0] ram_rdata = 24'h3ca5c3;
   logic [2:0] ext_cnt = 3'h0;
   logic [1:0] pll_cnt = 2'h0;
   logic [31:0] wb_dat_o, frame;
   logic wb_ack_o, ram_rd, ram_wr, bit_clock, word_select_clock, serial_data_line;
   logic serial_data_in_p00, serial_data_in_p05, transfer_start_irq, transfer_end_irq;
   logic [12:0] ram_addr, work_count, work_addr;
   logic [23:0] ram_wdata;
   logic [7:0] q;
   int num_errors = 0, num_checks = 0, n;
   asc_row_type rows [9];

   always #10 sys_clk = ~sys_clk;
   // Master clock candidates: PLL period 4 cycles, timer pin period 6
   always @(posedge sys_clk) begin
      ext_cnt <= (ext_cnt == 3'h5) ? 3'h0 : ext_cnt + 3'h1;
      external_timer_input_pin <= (ext_cnt < 3'h3);
      pll_cnt <= pll_cnt + 2'h1;
      pll_clock_in <= pll_cnt[1];
   end

   asc_core i_asc_core (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .external_timer_input_pin, .pll_clock_in,
      .serial_data_in_p00, .serial_data_in_p05, .prog_count, .prog_addr, .ram_rdata, .ram_addr,
      .ram_rd, .ram_wr, .ram_wdata, .bit_clock, .word_select_clock, .serial_data_line,
      .work_count, .work_addr, .transfer_start_irq, .transfer_end_irq);
   asc_codec i_asc_codec (.bit_clock, .word_select_clock, .serial_data_line,
      .serial_data_in_p00, .serial_data_in_p05, .frame);

   // ==========================================================
   // Tasks
   task automatic end_sim;
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hang;
      num_errors++;
      end_sim;
   endtask
   // Request held until ack is sampled high at a rising edge; data taken at that edge
   task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] d);
      int k;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) hang;
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk("register", {24'h0, exp}, {24'h0, q});
   endtask
   task automatic wait_hi(input int w);
      int k;
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while ((w == 0 ? ram_rd : w == 1 ? ram_wr : transfer_start_irq) !== 1'b1 && k < 4000);
      if (k >= 4000) hang;
   endtask
   // Counts RAM moves across a number of word-select changes
   task automatic ws_edges(input int e, output int rds);
      int k;
      logic w;
      k = 0;
      rds = 0;
      w = word_select_clock;
      while (e > 0) begin
         @(negedge sys_clk);
         k++;
         if (k > 8000) hang;
         if (ram_rd === 1'b1) rds++;
         if (word_select_clock !== w) e--;
         w = word_select_clock;
      end
   endtask
   task automatic period(output int p);
      int k, r;
      logic b;
      k = 0;
      r = 0;
      p = 0;
      b = bit_clock;
      while (r < 2) begin
         @(negedge sys_clk);
         k++;
         if (k > 500) hang;
         if (r == 1) p++;
         if (bit_clock === 1'b1 && b !== 1'b1) r++;
         b = bit_clock;
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rows = '{'{8'h64, 8'h00, 8'h00, 8'h02, 8'h01, 2, 32'h00a5c300},
               '{8'h60, 8'h00, 8'h00, 8'h03, 8'h01, 2, 32'h00c3a500},
               '{8'h64, 8'h20, 8'h00, 8'h01, 8'h01, 4, 32'h0000a5c3},
               '{8'h64, 8'h08, 8'h04, 8'h00, 8'h01, 8, 32'h0052e180},
               '{8'h64, 8'hc0, 8'h01, 8'h00, 8'h01, 6, 32'h3ca5c300},
               '{8'h64, 8'ha0, 8'h01, 8'h01, 8'h01, 4, 32'h000ca5c3},
               '{8'h64, 8'h40, 8'h00, 8'h02, 8'h01, 2, 32'h002970c0},
               '{8'h64, 8'h00, 8'hc0, 8'h02, 8'h00, 8, 32'h00a5c300},
               '{8'h64, 8'h04, 8'h00, 8'h02, 8'h01, 12, 32'h00a5c300}};
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(ASC_IDX_CTRL, 8'h00);
      rchk(ASC_IDX_MODE, 8'h00);
      rchk(ASC_IDX_CLK, 8'h00);
      rchk(16'h0001, 8'h00);
      foreach (rows[i]) begin
         wb(1'b1, ASC_IDX_CTRL, 8'h00);
         wb(1'b1, ASC_IDX_RATE, rows[i].rate);
         wb(1'b1, ASC_IDX_SRC, rows[i].src);
         wb(1'b1, ASC_IDX_CLK, rows[i].clk);
         wb(1'b1, ASC_IDX_MODE, rows[i].mode);
         wb(1'b1, ASC_IDX_CTRL, rows[i].ctl);
         ws_edges(4, n);
         period(n);
         chk("bit clock period", rows[i].per, n);
         chk("frame", rows[i].frame, frame);
         rchk(ASC_IDX_CTRL, rows[i].ctl);
      end
      // Receive through loopback, on each input pin
      wb(1'b1, ASC_IDX_MODE, 8'h10);
      wb(1'b1, ASC_IDX_CTRL, 8'h6c);
      ws_edges(4, n);
      wait_hi(1);
      chk("rx word", 32'h0000a5c3, {16'h0, ram_wdata[15:0]});
      wb(1'b1, ASC_IDX_MODE, 8'h00);
      ws_edges(4, n);
      wait_hi(1);
      chk("rx word", 32'h00005a3c, {16'h0, ram_wdata[15:0]});
      // Counted transfer with auto-stop; programmable copies rewritten mid-run
      wb(1'b1, ASC_IDX_CTRL, 8'h00);
      wb(1'b1, ASC_IDX_MODE, 8'h01);
      prog_count <= 13'h0006;
      prog_addr <= 13'h0100;
      wb(1'b1, ASC_IDX_CTRL, 8'h75);
      wait_hi(0);
      chk("first address", 32'h100, {19'h0, ram_addr});
      prog_count <= 13'h0040;
      prog_addr <= 13'h0300;
      wait_hi(2);
      chk("start request", 1, transfer_start_irq);
      n = 1;
      for (int k = 0; transfer_end_irq !== 1'b1; k++) begin
         @(negedge sys_clk);
         if (k > 4000) hang;
         if (ram_rd === 1'b1) n++;
      end
      chk("moves", 3, n);
      chk("address page", 32'h1, {27'h0, ram_addr[12:8]});
      ws_edges(5, n);
      chk("moves after end", 0, n);
      rchk(ASC_IDX_CTRL, 8'h57);
      rchk(ASC_IDX_MODE, 8'h03);
      wb(1'b1, ASC_IDX_CTRL, 8'h55);
      repeat (2) @(negedge sys_clk);
      chk("end request", 0, transfer_end_irq);
      // Run cleared mid-transfer, then reset in mid-run
      wb(1'b1, ASC_IDX_CTRL, 8'h64);
      ws_edges(3, n);
      wb(1'b1, ASC_IDX_CTRL, 8'h44);
      ws_edges(3, n);
      chk("moves after clear", 0, n);
      wb(1'b1, ASC_IDX_CTRL, 8'h64);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(ASC_IDX_CTRL, 8'h00);
      wb(1'b1, ASC_IDX_CLK, 8'h04);
      @(negedge sys_clk);
      chk("idle word select", 0, word_select_clock);
      end_sim;
   end
endmodule
